// ### rtl/lpks_top.sv
// long-press key detector requesting switch-off
`timescale 1ns/1ps
`include "lpks_defs.svh"
module lpks_top #(
    // counter width
    parameter int CNT_W = `LPKS_CNT_W,
    // hold choices in ticks, picked by the duration select
    parameter logic [CNT_W-1:0] HOLD_0 = `LPKS_HOLD_0,
    parameter logic [CNT_W-1:0] HOLD_1 = `LPKS_HOLD_1,
    parameter logic [CNT_W-1:0] HOLD_2 = `LPKS_HOLD_2,
    parameter logic [CNT_W-1:0] HOLD_3 = `LPKS_HOLD_3,
    // flag-to-request delay in ticks; keeps the flag ahead of the request
    parameter logic [CNT_W-1:0] OFF_DELAY = `LPKS_OFF_DELAY
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // key pin, active low
    input wire logic power_on_key_pin_n,
    // configuration
    input wire lpks_pkg::lpks_cfg_t cfg,
    // software clear of the key-hold interrupt, one-cycle pulse
    input wire logic irq_clear,
    // results
    output logic key_hold_irq,
    output logic switch_off_req
);
    // *****************************************************
    // state
    // *****************************************************
    lpks_pkg::lpks_state_t state; // detector state
    lpks_pkg::lpks_state_t next_state;
    logic flag; // sticky interrupt flag
    logic next_flag;
    logic off_req; // latched switch-off request
    logic next_off_req;
    logic key_held; // key pressed level
    logic hold_done; // hold time reached
    logic delay_done; // interrupt-to-off delay reached
    logic [CNT_W-1:0] limit; // selected hold time

    assign key_held = !power_on_key_pin_n;

    // decode the duration select into a tick count
    function automatic logic [CNT_W-1:0] hold_ticks(
        input logic [1:0] sel
    );
        unique case (sel)
            2'h0: hold_ticks = HOLD_0;
            2'h1: hold_ticks = HOLD_1;
            2'h2: hold_ticks = HOLD_2;
            2'h3: hold_ticks = HOLD_3;
        endcase
    endfunction

    // duration comes from the select field
    assign limit = hold_ticks(cfg.hold_duration_select); // RULE2

    // *****************************************************
    // timers
    // *****************************************************
    // counts key hold; restarts on release
    lpks_hold_timer #(.CNT_W(CNT_W)) u_hold (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .run(key_held && state == lpks_pkg::LPKS_COUNT),
        .limit(limit),
        .done(hold_done)
    );

    // delay from interrupt to switch-off so the flag leads
    lpks_hold_timer #(.CNT_W(CNT_W)) u_delay (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .run(state == lpks_pkg::LPKS_FLAGGED),
        .limit(OFF_DELAY),
        .done(delay_done)
    );

    // *****************************************************
    // control
    // *****************************************************
    // next state, flag and request
    always_comb begin
        next_state = state;
        next_flag = flag;
        next_off_req = off_req;
        // software clear; a new detection in the same cycle wins
        if (irq_clear) begin
            next_flag = 1'b0; // RULE6
        end
        unique case (state)
            lpks_pkg::LPKS_IDLE: begin
                if (key_held) begin
                    next_state = lpks_pkg::LPKS_COUNT;
                end
            end
            lpks_pkg::LPKS_COUNT: begin
                if (!key_held) begin
                    next_state = lpks_pkg::LPKS_IDLE;
                end else if (hold_done) begin
                    // interrupt first, switch-off later
                    next_flag = 1'b1; // RULE1 RULE6
                    next_state = lpks_pkg::LPKS_FLAGGED;
                end
            end
            lpks_pkg::LPKS_FLAGGED: begin
                if (!cfg.cancel_policy_select && irq_clear) begin
                    // cancel only while policy 0
                    next_state = lpks_pkg::LPKS_WAIT_RELEASE; // RULE3
                end else if (delay_done) begin
                    // policy 1 ignores clears; policy 0 uncleared
                    next_off_req = 1'b1; // RULE1 RULE4 RULE5
                    next_state = lpks_pkg::LPKS_WAIT_RELEASE;
                end
            end
            lpks_pkg::LPKS_WAIT_RELEASE: begin
                // no re-arm until the key is let go
                if (!key_held) begin
                    next_state = lpks_pkg::LPKS_IDLE;
                end
            end
        endcase
    end

    // register; request held until reset by the sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= lpks_pkg::LPKS_IDLE;
            flag <= 1'b0; // RULE6
            off_req <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            flag <= next_flag;
            off_req <= next_off_req;
        end
    end

    assign key_hold_irq = flag;
    assign switch_off_req = off_req;

    // *****************************************************
    // checks
    // *****************************************************
    property p_irq_before_off;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(off_req) |-> $past(state) == lpks_pkg::LPKS_FLAGGED;
    endproperty
    a_irq_before_off: assert property (p_irq_before_off) // RULE1
        else $error("switch-off without prior flag state");

    property p_flag_on_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && state == lpks_pkg::LPKS_COUNT && key_held && hold_done)
        |=> flag && state == lpks_pkg::LPKS_FLAGGED;
    endproperty
    a_flag_on_hold: assert property (p_flag_on_hold) // RULE2
        else $error("hold reached but flag not raised");

    property p_cancel;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && state == lpks_pkg::LPKS_FLAGGED && irq_clear
         && !cfg.cancel_policy_select)
        |=> !off_req && state == lpks_pkg::LPKS_WAIT_RELEASE;
    endproperty
    a_cancel: assert property (p_cancel) // RULE3
        else $error("clear under policy 0 did not cancel");

    property p_execute;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && state == lpks_pkg::LPKS_FLAGGED && delay_done
         && !irq_clear) |=> off_req;
    endproperty
    a_execute: assert property (p_execute) // RULE4
        else $error("uncleared hold did not switch off");

    property p_no_cancel;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && state == lpks_pkg::LPKS_FLAGGED && delay_done
         && cfg.cancel_policy_select) |=> off_req;
    endproperty
    a_no_cancel: assert property (p_no_cancel) // RULE5
        else $error("policy 1 allowed a cancel");

    property p_sticky;
        @(posedge sys_clk) disable iff (!rst_n)
        (flag && !irq_clear) |=> flag;
    endproperty
    a_sticky: assert property (p_sticky) // RULE6
        else $error("flag dropped without clear");

    // the flag only rises out of a completed hold count
    property p_flag_from_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(flag) |-> $past(state) == lpks_pkg::LPKS_COUNT
            && $past(hold_done);
    endproperty
    a_flag_from_hold: assert property (p_flag_from_hold) // RULE2
        else $error("flag rose without a completed hold");

    // a clear with no detection in the same cycle drops the flag
    property p_clear_drops;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && irq_clear
         && !(state == lpks_pkg::LPKS_COUNT && key_held && hold_done))
        |=> !flag;
    endproperty
    a_clear_drops: assert property (p_clear_drops) // RULE6
        else $error("clear did not drop the flag");

    // detection and clear in one cycle: the set wins
    property p_set_wins;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && irq_clear && state == lpks_pkg::LPKS_COUNT
         && key_held && hold_done) |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins) // RULE6
        else $error("clear beat a detection in the same cycle");

    // policy 1 leaves the flagged state only with a request
    property p_policy1_holds;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && state == lpks_pkg::LPKS_FLAGGED
         && cfg.cancel_policy_select)
        |=> state == lpks_pkg::LPKS_FLAGGED || off_req;
    endproperty
    a_policy1_holds: assert property (p_policy1_holds) // RULE5
        else $error("policy 1 left flagged state without request");

    // once raised, the request stays up until reset
    property p_off_sticky;
        @(posedge sys_clk) disable iff (!rst_n)
        off_req |=> off_req;
    endproperty
    a_off_sticky: assert property (p_off_sticky) // RULE4
        else $error("switch-off request dropped before reset");

    // a low enable freezes state, flag and request, so holds stretch
    property p_frozen;
        @(posedge sys_clk) disable iff (!rst_n)
        !clk_en |=> $stable(state) && $stable(flag) && $stable(off_req);
    endproperty
    a_frozen: assert property (p_frozen) // RULE2
        else $error("state moved while the enable was low");
endmodule

// ### rtl/lpks_defs.svh
// constants for the long-press key shutdown block
// Behaviour
// RULE1: raise interrupt first, then request switch-off
// RULE2: hold time taken from duration-select field
// RULE3: policy 0: clear while held cancels switch-off
// RULE4: policy 0: uncleared flag while held powers off
// RULE5: policy 1 (default): no cancel while held
// RULE6: flag sticky until software clear or reset
`ifndef LPKS_DEFS_SVH
`define LPKS_DEFS_SVH

// *****************************************************
// hold duration choices (in slow-clock ticks, 32 kHz base)
// *****************************************************
`define LPKS_SEL_W 2
`define LPKS_CNT_W 20
`define LPKS_HOLD_0 20'h3E800
`define LPKS_HOLD_1 20'h5DC00
`define LPKS_HOLD_2 20'h7D000
`define LPKS_HOLD_3 20'h9C400

// *****************************************************
// delay between interrupt and switch-off request, in ticks
// *****************************************************
`define LPKS_OFF_DELAY 20'h00010

// *****************************************************
// reset values
// *****************************************************
`define LPKS_POLICY_RST 1'b1
`define LPKS_SEL_RST 2'h0

`endif

// ### rtl/lpks_pkg.sv
// types shared by the long-press key shutdown block
package lpks_pkg;
    // detector states
    typedef enum logic [1:0] {
        LPKS_IDLE,
        LPKS_COUNT,
        LPKS_FLAGGED,
        LPKS_WAIT_RELEASE
    } lpks_state_t;

    // configuration carried together
    typedef struct packed {
        logic [1:0] hold_duration_select;
        logic cancel_policy_select;
    } lpks_cfg_t;
endpackage

// ### rtl/lpks_hold_timer.sv
// hold-time counter with selectable limit
`timescale 1ns/1ps
`include "lpks_defs.svh"
module lpks_hold_timer #(
    parameter int CNT_W = `LPKS_CNT_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // control
    input wire logic run,
    input wire logic [CNT_W-1:0] limit,
    // status
    output logic done
);
    logic [CNT_W-1:0] count; // ticks while running
    logic [CNT_W-1:0] next_count;

    // count while run, restart when run drops; saturate at limit
    always_comb begin
        next_count = count;
        if (!run) begin
            next_count = '0;
        end else if (count < limit) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clk_en) begin
            count <= next_count;
        end
    end

    // done once the limit is reached while still running
    assign done = run && (count >= limit);
endmodule

// ### tb/lpks_key_model.sv
// push-button model that drives the active-low key pin
`timescale 1ns/1ps
module lpks_key_model (
    // request from the bench
    input wire logic pressed,
    // key pin, pulled up while the button is released
    output logic power_on_key_pin_n
);
    // the pull-up returns the pin high as soon as the button lets go
    always_comb begin
        power_on_key_pin_n = ~pressed;
    end
endmodule

// ### tb/test_long_press_key_shutdown.sv
// self-checking bench for the long-press key shutdown block
`timescale 1ns/1ps
`include "lpks_defs.svh"
module test_long_press_key_shutdown;
    // ****************
    // signals
    // ****************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1; // gating is held open except for the stall in s_frozen
    logic pressed = 1'b0;
    logic irq_clear = 1'b0;
    lpks_pkg::lpks_cfg_t cfg = 3'h1; // reset default: no cancel
    wire logic power_on_key_pin_n;
    logic key_hold_irq;
    logic switch_off_req;
    int failures = 0;
    int compares = 0;
    int n;
    // short hold choices keep the run brief; the delay keeps its default
    localparam logic [`LPKS_CNT_W-1:0] TB_HOLD_0 = 20'h00064;
    localparam logic [`LPKS_CNT_W-1:0] TB_HOLD_1 = 20'h000C8;
    localparam logic [`LPKS_CNT_W-1:0] TB_HOLD_2 = 20'h0012C;
    localparam logic [`LPKS_CNT_W-1:0] TB_HOLD_3 = 20'h00190;

    // 100 ns period
    always #50 sys_clk = ~sys_clk;

    lpks_top #(.HOLD_0(TB_HOLD_0), .HOLD_1(TB_HOLD_1), .HOLD_2(TB_HOLD_2),
        .HOLD_3(TB_HOLD_3)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(clk_en),
        .power_on_key_pin_n(power_on_key_pin_n), .cfg(cfg),
        .irq_clear(irq_clear), .key_hold_irq(key_hold_irq),
        .switch_off_req(switch_off_req));
    lpks_key_model u_key (.pressed(pressed),
        .power_on_key_pin_n(power_on_key_pin_n));

    // ****************
    // helpers
    // ****************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // reset is level, so ten low cycles also clear the sticky request
    task automatic do_reset(input lpks_pkg::lpks_cfg_t c);
        @(negedge sys_clk);
        rst_n = 1'b0;
        pressed = 1'b0;
        cfg = c;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        check({key_hold_irq, switch_off_req}, 2'h0);
    endtask

    // press and count cycles until the flag shows up
    task automatic hold_to_flag(input int limit);
        n = 0;
        pressed = 1'b1;
        while (key_hold_irq !== 1'b1 && n < limit + 50) begin
            @(negedge sys_clk);
            n++;
        end
        check(n >= limit && n <= limit + 4, 1'b1);
        check(switch_off_req, 1'b0);
    endtask

    // the request follows the flag after the fixed delay;
    // spent is the number of edges already waited since the flag
    task automatic wait_off(input int spent);
        n = spent;
        while (switch_off_req !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check(n >= `LPKS_OFF_DELAY && n <= `LPKS_OFF_DELAY + 4, 1'b1);
    endtask

    task automatic pulse_clear;
        irq_clear = 1'b1;
        @(negedge sys_clk);
        irq_clear = 1'b0;
    endtask

    // ****************
    // scenarios
    // ****************
    // policy 1: a clear drops the flag but cannot stop the switch-off
    task automatic s_forced_off;
        do_reset(3'h1);
        hold_to_flag(TB_HOLD_0);
        repeat (4) @(negedge sys_clk);
        check(key_hold_irq, 1'b1);
        pulse_clear();
        check(key_hold_irq, 1'b0);
        wait_off(5);
    endtask

    // policy 0: a clear while still held cancels the switch-off
    task automatic s_cancel;
        do_reset(3'h0);
        hold_to_flag(TB_HOLD_0);
        pulse_clear();
        repeat (40) @(negedge sys_clk);
        check({key_hold_irq, switch_off_req}, 2'h0);
    endtask

    // policy 0, second hold choice, flag left alone: switch-off happens
    task automatic s_no_clear;
        do_reset(3'h2);
        hold_to_flag(TB_HOLD_1);
        wait_off(0);
        check(key_hold_irq, 1'b1);
    endtask

    // policy 1, last hold choice; a low enable stalls the count
    task automatic s_frozen;
        do_reset(3'h7);
        pressed = 1'b1;
        repeat (5) @(negedge sys_clk);
        clk_en = 1'b0;
        // stalled for as many cycles as the hold, so any leak would raise the flag
        repeat (TB_HOLD_3) @(negedge sys_clk);
        check(key_hold_irq, 1'b0);
        clk_en = 1'b1;
        // a few ticks were counted before the stall
        hold_to_flag(TB_HOLD_3 - 5);
        wait_off(0);
    endtask

    // policy 0, third hold choice: early release restarts, cancel re-arms
    task automatic s_restart;
        do_reset(3'h4);
        pressed = 1'b1;
        repeat (TB_HOLD_2 - 10) @(negedge sys_clk);
        pressed = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(key_hold_irq, 1'b0);
        hold_to_flag(TB_HOLD_2);
        pulse_clear();
        pressed = 1'b0;
        repeat (2) @(negedge sys_clk);
        check({key_hold_irq, switch_off_req}, 2'h0);
        hold_to_flag(TB_HOLD_2);
        wait_off(0);
    endtask

    task automatic complete_run;
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // sized on the shortened hold choices with a wide margin
    initial begin
        #((5 * TB_HOLD_3 + 2000) * 100);
        failures++;
        complete_run();
    end

    initial begin
        s_forced_off();
        s_cancel();
        s_no_clear();
        s_frozen();
        s_restart();
        complete_run();
    end
endmodule
